// File: verilog/pdc_pkg.sv
// Constants shared by the power-down control block.
// Assumes a 250 MHz ref_clk and a 32-bit AXI4-Lite register port.
package pdc_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_DIV     = 8'h04;
	localparam logic [7:0] OFF_STATUS  = 8'h08;
	localparam logic [7:0] OFF_PEND    = 8'h0C;
	localparam logic [7:0] OFF_PDATA   = 8'h10;
	localparam logic [7:0] OFF_PDIR    = 8'h14;
	localparam logic [7:0] OFF_HELD_PC = 8'h18;
	localparam logic [7:0] OFF_EVCNT   = 8'h1C;

	// Values of the power_down_control register.
	localparam logic [7:0] CTRL_STOP_ARM = 8'h5A;
	localparam logic [7:0] CTRL_SLEEP    = 8'h0F;
	localparam logic [7:0] CTRL_RST      = 8'h00;

	// Interval timer clock division select and its reset value.
	localparam int         DIV_W         = 3;
	localparam logic [2:0] DIV_RST       = 3'h3; // Keeps the power-up wait short.
	localparam logic [2:0] DIV_MAX       = 3'h7;
	localparam logic [10:0] PRE_FULL     = 11'h7FF;

	// Basic interval timer count limits.
	localparam logic [7:0] BIT_START = 8'h00;
	localparam logic [7:0] BIT_END   = 8'hFF;

	// Wake source bit positions.
	localparam int WAKE_N   = 5;
	localparam int WK_EXT   = 0;
	localparam int WK_EC0   = 1;
	localparam int WK_EC1   = 2;
	localparam int WK_EC2   = 3;
	localparam int WK_SIO   = 4;

	// AXI4-Lite responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Power states, Gray coded along RUN, STOP, STAB.
	typedef enum logic [1:0] {
		ST_RUN   = 2'h0,
		ST_STOP  = 2'h1,
		ST_STAB  = 2'h3,
		ST_SLEEP = 2'h2
	} pdc_state_t;

endpackage

// File: verilog/pdc_edge_sync.sv
// Two-stage synchroniser for one pin with a rising edge pulse output.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps

module pdc_edge_sync (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst_b,
	// Pin and result.
	input  wire logic pin_in,
	output logic      rise_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Only sync_reg reads the first stage.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// One-cycle pulse on each low to high change.
	assign rise_pulse = sync_reg & ~last_reg;

endmodule // pdc_edge_sync

// File: verilog/pdc_power_ctrl.sv
// Power-down control: STOP and SLEEP entry, wake-up, stabilization wait.
// Assumes a CPU on ref_clk that pulses stop_exec and an AXI4-Lite master.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - STOP halts oscillator, system clock and peripheral clock; registers kept.
// - STOP freezes timer, watchdog, buzzer and converter; latched state kept.
// - Port pins keep driving latched data and direction during STOP.
// - Held program counter is the address after the stop instruction.
// - STOP entered only by stop instruction with control holding 5AH.
// - STOP ends on reset, external interrupt, event inputs or serial port.
// - Reset restores control registers; memory contents are untouched.
// - Interrupt wake with mask flag 1 vectors to the service routine.
// - Interrupt wake with mask flag 0 resumes after stop, no vector.
// - On wake the interval timer restarts from 00 to FF; run at overflow.
// - In STOP the event counter still counts external edges.
// - In STOP the serial port runs only from its external clock.
// - After reset or wake the wait is one full interval timer cycle.
// - Reset returns the divider to default; reset wait uses it.
// - Writing 0FH to the control register enters SLEEP.
// - In SLEEP the oscillator and all peripherals keep running.
// - SLEEP ends on reset or any enabled interrupt.
// - Release from STOP clears the control register.
module pdc_power_ctrl (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// AXI4-Lite write channels.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// CPU side.
	input  wire logic        stop_exec,
	input  wire logic [15:0] stop_next_pc,
	input  wire logic        i_flag,
	input  wire logic        irq_any,
	output logic             cpu_run,
	output logic             cpu_resume,
	output logic             cpu_vector,
	output logic [15:0]      held_pc,
	// Wake pins.
	input  wire logic        ext_int_pin,
	input  wire logic        event_count_input_0,
	input  wire logic        event_count_input_1,
	input  wire logic        event_count_input_2,
	input  wire logic        serial_shift_port_req,
	input  wire logic        sio_ext_clk_sel,
	// Clock enables and ports.
	output logic             osc_en,
	output logic             sys_clk_en,
	output logic             periph_clk_en,
	output logic             sio_clk_en,
	output logic [7:0]       port_out,
	output logic [7:0]       port_oe_b,
	output logic [pdc_pkg::WAKE_N-1:0] wake_pending
);

	pdc_pkg::pdc_state_t state_reg;
	pdc_pkg::pdc_state_t state_next;

	logic [7:0]  ctrl_reg;
	logic [2:0]  div_reg;
	logic [10:0] pre_reg;
	logic [7:0]  bit_cnt_reg;
	logic [7:0]  pdata_reg;
	logic [7:0]  pdir_reg;
	logic [7:0]  evcnt_reg;
	logic [15:0] pc_reg;
	logic [pdc_pkg::WAKE_N-1:0] pend_reg;
	logic [pdc_pkg::WAKE_N-1:0] wake_raw;
	logic [pdc_pkg::WAKE_N-1:0] wake_ok;
	logic [pdc_pkg::WAKE_N-1:0] pend_clr;
	logic        irq_wake_reg;
	logic        resume_reg;
	logic        vector_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        w_lane0_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        wr_do;
	logic        wr_hit;
	logic        stop_wake;
	logic        sleep_wake;
	logic        bit_tick;
	logic        bit_ovf;
	logic [10:0] pre_mask;
	logic        ctrl_wr;
	logic        rst_wait_reg;

	// Each wake pin is synchronised and edge detected.
	for (genvar g = 0; g < pdc_pkg::WAKE_N; g++) begin : g_wake
		logic pin_sel;
		assign pin_sel = (g == pdc_pkg::WK_EXT) ? ext_int_pin :
			(g == pdc_pkg::WK_EC0) ? event_count_input_0 :
			(g == pdc_pkg::WK_EC1) ? event_count_input_1 :
			(g == pdc_pkg::WK_EC2) ? event_count_input_2 : serial_shift_port_req;
		pdc_edge_sync u_sync (
			.ref_clk    (ref_clk),
			.rst_b      (rst_b),
			.pin_in     (pin_sel),
			.rise_pulse (wake_raw[g])
		);
	end

	// The serial request only counts in STOP when its clock is external.
	always_comb begin
		wake_ok = wake_raw;
		if (state_reg == pdc_pkg::ST_STOP && !sio_ext_clk_sel) begin
			wake_ok[pdc_pkg::WK_SIO] = 1'b0;
		end
	end

	// Only the listed sources end STOP; SLEEP also takes any interrupt.
	assign stop_wake  = |wake_ok;
	assign sleep_wake = stop_wake | irq_any;

	// Write happens once both address and data are held.
	assign wr_do   = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign ctrl_wr = wr_do & w_lane0_reg & (aw_addr_reg == pdc_pkg::OFF_CTRL);

	// Timer tick divides ref_clk by 2^(4+div); the wait after reset uses the reset division.
	assign pre_mask = pdc_pkg::PRE_FULL >> (pdc_pkg::DIV_MAX
		- (rst_wait_reg ? pdc_pkg::DIV_RST : div_reg));
	assign bit_tick = (pre_reg == pre_mask);
	assign bit_ovf  = bit_tick & (bit_cnt_reg == pdc_pkg::BIT_END);

	// Next power state.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pdc_pkg::ST_RUN: begin
				if (stop_exec && ctrl_reg == pdc_pkg::CTRL_STOP_ARM) begin
					state_next = pdc_pkg::ST_STOP;
				end else if (ctrl_wr && w_data_reg[7:0] == pdc_pkg::CTRL_SLEEP) begin
					state_next = pdc_pkg::ST_SLEEP;
				end
			end
			pdc_pkg::ST_STOP: begin
				if (stop_wake) begin
					state_next = pdc_pkg::ST_STAB;
				end
			end
			pdc_pkg::ST_SLEEP: begin
				if (sleep_wake) begin
					state_next = pdc_pkg::ST_STAB;
				end
			end
			pdc_pkg::ST_STAB: begin
				if (bit_ovf) begin
					state_next = pdc_pkg::ST_RUN;
				end
			end
			default: state_next = pdc_pkg::ST_STAB;
		endcase
	end

	// Reset starts in the stabilization wait.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_reg <= pdc_pkg::ST_STAB;
		end else begin
			state_reg <= state_next;
		end
	end

	// Marks the wait after reset, so a divider write made during it cannot change its length.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rst_wait_reg <= 1'b1;
		end else if (state_reg == pdc_pkg::ST_STAB && bit_ovf) begin
			rst_wait_reg <= 1'b0;
		end
	end

	// Interval timer: frozen in STOP, restarted at 00 on every wake.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre_reg     <= '0;
			bit_cnt_reg <= pdc_pkg::BIT_START;
		end else if (state_reg != pdc_pkg::ST_STAB && state_next == pdc_pkg::ST_STAB) begin
			pre_reg     <= '0;
			bit_cnt_reg <= pdc_pkg::BIT_START;
		end else if (state_reg != pdc_pkg::ST_STOP) begin
			pre_reg <= bit_tick ? '0 : pre_reg + 11'h001;
			if (bit_tick) begin
				bit_cnt_reg <= bit_cnt_reg + 8'h01;
			end
		end
	end

	// Control register: whole-byte writes, cleared on STOP release.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctrl_reg <= pdc_pkg::CTRL_RST;
		end else if (state_reg == pdc_pkg::ST_STOP) begin
			if (stop_wake) begin
				ctrl_reg <= pdc_pkg::CTRL_RST;
			end
		end else if (ctrl_wr) begin
			ctrl_reg <= w_data_reg[7:0];
		end
	end

	// Divider, port data and direction; reset restores defaults.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			div_reg   <= pdc_pkg::DIV_RST;
			pdata_reg <= '0;
			pdir_reg  <= '0;
		end else if (wr_do && w_lane0_reg && state_reg != pdc_pkg::ST_STOP) begin
			if (aw_addr_reg == pdc_pkg::OFF_DIV) begin
				div_reg <= w_data_reg[pdc_pkg::DIV_W-1:0];
			end else if (aw_addr_reg == pdc_pkg::OFF_PDATA) begin
				pdata_reg <= w_data_reg[7:0];
			end else if (aw_addr_reg == pdc_pkg::OFF_PDIR) begin
				pdir_reg <= w_data_reg[7:0];
			end
		end
	end

	// Return address is caught at the stop instruction and held.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pc_reg <= '0;
		end else if (state_reg == pdc_pkg::ST_RUN && state_next == pdc_pkg::ST_STOP) begin
			pc_reg <= stop_next_pc;
		end
	end

	// Event counter on input 0 counts in every state, STOP included.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			evcnt_reg <= '0;
		end else if (wake_raw[pdc_pkg::WK_EC0]) begin
			evcnt_reg <= evcnt_reg + 8'h01;
		end
	end

	// Pending wake bits: software clears by writing one, a new set wins.
	always_comb begin
		pend_clr = '0;
		if (wr_do && w_lane0_reg && aw_addr_reg == pdc_pkg::OFF_PEND) begin
			pend_clr = w_data_reg[pdc_pkg::WAKE_N-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~pend_clr) | wake_ok;
		end
	end

	// Remember whether an interrupt or a reset started the wait.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			irq_wake_reg <= 1'b0;
		end else if (state_reg != pdc_pkg::ST_STAB && state_next == pdc_pkg::ST_STAB) begin
			irq_wake_reg <= 1'b1;
		end else if (state_reg == pdc_pkg::ST_RUN) begin
			irq_wake_reg <= 1'b0;
		end
	end

	// Resume pulse at overflow; vector only when interrupts are unmasked.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			resume_reg <= 1'b0;
			vector_reg <= 1'b0;
		end else begin
			resume_reg <= (state_reg == pdc_pkg::ST_STAB) & bit_ovf;
			vector_reg <= (state_reg == pdc_pkg::ST_STAB) & bit_ovf
				& irq_wake_reg & i_flag;
		end
	end

	// Write address and data are taken in either order.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_lane0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg  <= 1'b1;
				w_data_reg  <= s_axi_wdata;
				w_lane0_reg <= s_axi_wstrb[0];
			end else if (wr_do) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// Write decode answers with OKAY, or SLVERR for an unmapped or read-only word.
	always_comb begin
		wr_hit = 1'b0;
		if (aw_addr_reg == pdc_pkg::OFF_CTRL || aw_addr_reg == pdc_pkg::OFF_DIV) begin
			wr_hit = 1'b1;
		end else if (aw_addr_reg == pdc_pkg::OFF_PEND || aw_addr_reg == pdc_pkg::OFF_PDATA) begin
			wr_hit = 1'b1;
		end else if (aw_addr_reg == pdc_pkg::OFF_PDIR) begin
			wr_hit = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= pdc_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read path, one read at a time.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= pdc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= pdc_pkg::RESP_OKAY;
			rdata_reg  <= '0;
			if (s_axi_araddr == pdc_pkg::OFF_CTRL) begin
				rdata_reg[7:0] <= ctrl_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_DIV) begin
				rdata_reg[pdc_pkg::DIV_W-1:0] <= div_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_STATUS) begin
				rdata_reg[7:0] <= {6'h00, state_reg};
			end else if (s_axi_araddr == pdc_pkg::OFF_PEND) begin
				rdata_reg[pdc_pkg::WAKE_N-1:0] <= pend_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_PDATA) begin
				rdata_reg[7:0] <= pdata_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_PDIR) begin
				rdata_reg[7:0] <= pdir_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_HELD_PC) begin
				rdata_reg[15:0] <= pc_reg;
			end else if (s_axi_araddr == pdc_pkg::OFF_EVCNT) begin
				rdata_reg[15:0] <= {bit_cnt_reg, evcnt_reg};
			end else begin
				rresp_reg <= pdc_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Bus outputs.
	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Clock enables decoded from the state flop; SLEEP keeps them on.
	assign osc_en        = (state_reg != pdc_pkg::ST_STOP);
	assign sys_clk_en    = (state_reg != pdc_pkg::ST_STOP);
	assign periph_clk_en = (state_reg != pdc_pkg::ST_STOP);
	assign sio_clk_en    = (state_reg != pdc_pkg::ST_STOP) | sio_ext_clk_sel;
	assign cpu_run       = (state_reg == pdc_pkg::ST_RUN);
	assign cpu_resume    = resume_reg;
	assign cpu_vector    = vector_reg;
	assign held_pc       = pc_reg;
	assign port_out      = pdata_reg;
	assign port_oe_b     = ~pdir_reg;
	assign wake_pending  = pend_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_stop_wake;
		state_reg == pdc_pkg::ST_STOP && stop_wake;
	endsequence

	sequence s_stab_end;
		state_reg == pdc_pkg::ST_STAB && bit_ovf;
	endsequence

	a_stop_entry: assert property (state_reg == pdc_pkg::ST_RUN && stop_exec
		&& ctrl_reg == pdc_pkg::CTRL_STOP_ARM |=> state_reg == pdc_pkg::ST_STOP)
		else $error("Armed stop did not enter STOP.");
	a_unarmed_stop: assert property (state_reg == pdc_pkg::ST_RUN && stop_exec
		&& ctrl_reg != pdc_pkg::CTRL_STOP_ARM |=> state_reg != pdc_pkg::ST_STOP)
		else $error("Unarmed stop entered STOP.");
	a_clocks_off: assert property (state_reg == pdc_pkg::ST_STOP
		|-> !osc_en && !sys_clk_en && !periph_clk_en)
		else $error("Clock running in STOP.");
	a_pc_ports_held: assert property (state_reg == pdc_pkg::ST_STOP
		|=> $stable(held_pc) && $stable(port_out) && $stable(port_oe_b))
		else $error("State changed during STOP.");
	a_wake_restart: assert property (s_stop_wake |=> state_reg == pdc_pkg::ST_STAB
		&& bit_cnt_reg == pdc_pkg::BIT_START && ctrl_reg == pdc_pkg::CTRL_RST
		&& pend_reg != '0)
		else $error("Wake did not restart the wait.");
	a_vector_on: assert property (s_stab_end ##0 (irq_wake_reg && i_flag)
		|=> cpu_vector && cpu_resume ##1 cpu_run)
		else $error("Missing vector after wake.");
	a_vector_off: assert property (s_stab_end ##0 !i_flag
		|=> !cpu_vector && cpu_resume && cpu_run)
		else $error("Vector taken with interrupts masked.");
	a_sleep_entry: assert property (state_reg == pdc_pkg::ST_RUN && !stop_exec
		&& ctrl_wr && w_data_reg[7:0] == pdc_pkg::CTRL_SLEEP
		|=> state_reg == pdc_pkg::ST_SLEEP && osc_en && periph_clk_en)
		else $error("Sleep write did not enter SLEEP.");

endmodule // pdc_power_ctrl

// File: testbench/pdc_cpu_model.sv
// CPU core stand-in: steps a program address and issues the stop instruction.
// Assumes the power-down block on ref_clk with synchronous active-low rst_b.
`timescale 1ns/1ps

module pdc_cpu_model (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Power-down block side.
	input  wire logic        cpu_run,
	output logic             stop_exec,
	output logic [15:0]      stop_next_pc,
	output logic             i_flag,
	output logic             irq_any,
	// Bench controls.
	input  wire logic        want_stop,
	input  wire logic        want_irq,
	input  wire logic        want_iflag
);
	logic [15:0] pc_reg;
	logic        go;

	assign go = want_stop & cpu_run & ~stop_exec;

	// The address only moves while the core runs; a stop is a one-cycle pulse.
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pc_reg <= 16'h0100;
			stop_exec <= 1'b0;
			stop_next_pc <= 16'h0000;
		end else begin
			stop_exec <= go;
			if (go) begin
				stop_next_pc <= pc_reg + 16'h0001;
			end
			if (cpu_run) begin
				pc_reg <= pc_reg + 16'h0001;
			end
		end
	end

	// Interrupt mask and request levels follow the bench.
	always_ff @(posedge ref_clk) begin
		i_flag <= want_iflag & rst_b;
		irq_any <= want_irq & rst_b;
	end
endmodule // pdc_cpu_model

// File: testbench/stop_mode_power_down_control_tb.sv
// Self-checking bench for the power-down block: bus, STOP, SLEEP, wake.
// Assumes pdc_pkg, pdc_power_ctrl and pdc_cpu_model are compiled first.
`timescale 1ns/1ps

module stop_mode_power_down_control_tb;
	logic        ref_clk, rst_b;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        stop_exec, i_flag, irq_any, cpu_run, cpu_resume, cpu_vector;
	logic [15:0] stop_next_pc, held_pc;
	logic        ext_int_pin, serial_shift_port_req, sio_ext_clk_sel;
	logic        event_count_input_0, event_count_input_1, event_count_input_2;
	logic        osc_en, sys_clk_en, periph_clk_en, sio_clk_en;
	logic [7:0]  port_out, port_oe_b;
	logic [4:0]  wake_pending, pins;
	logic        want_stop, want_irq, want_iflag, vec;
	logic [31:0] d, e;
	logic [1:0]  r;
	int          num_errors = 0, checked = 0, cyc = 0, n;

	assign {serial_shift_port_req, event_count_input_2, event_count_input_1,
		event_count_input_0, ext_int_pin} = pins;

	pdc_power_ctrl uut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_exec, .stop_next_pc, .i_flag,
		.irq_any, .cpu_run, .cpu_resume, .cpu_vector, .held_pc, .ext_int_pin,
		.event_count_input_0, .event_count_input_1, .event_count_input_2,
		.serial_shift_port_req, .sio_ext_clk_sel, .osc_en, .sys_clk_en, .periph_clk_en,
		.sio_clk_en, .port_out, .port_oe_b, .wake_pending);

	pdc_cpu_model cpu (.ref_clk, .rst_b, .cpu_run, .stop_exec, .stop_next_pc, .i_flag,
		.irq_any, .want_stop, .want_irq, .want_iflag);

	// Free-running clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Cuts a hang short well beyond the longest expected run.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			num_errors++;
			$display("unexpected timeout: expected end of tests, seen %0d cycles", cyc);
			close_out();
		end
	end

	// Counts a comparison and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One register write; address and data are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// One register read.
	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		dv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Reads a register and compares data and response.
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		rd(a, d, r);
		chk(nm, d, exp);
		chk("rresp", 32'(r), 32'(pdc_pkg::RESP_OKAY));
	endtask

	// Has the core execute the stop instruction.
	task automatic do_stop();
		@(posedge ref_clk);
		want_stop <= 1'b1;
		@(posedge ref_clk);
		want_stop <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// Raises one wake pin for four cycles.
	task automatic pulse(input int k);
		@(posedge ref_clk);
		pins[k] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pins[k] <= 1'b0;
	endtask

	// Waits for the end of the stabilization wait.
	task automatic wres();
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!cpu_resume);
		vec = cpu_vector;
	endtask

	initial begin
		rst_b = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		pins = 5'h00;
		{sio_ext_clk_sel, want_stop, want_irq, want_iflag} = '0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		rchk("status", pdc_pkg::OFF_STATUS, 32'h3);
		rchk("divider", pdc_pkg::OFF_DIV, 32'(pdc_pkg::DIV_RST));
		rchk("ctrl", pdc_pkg::OFF_CTRL, 32'h0);
		wr(pdc_pkg::OFF_DIV, 32'h0, r);
		repeat (8000) @(posedge ref_clk);
		chk("early_run", 32'(cpu_run), 32'h0);
		// The power-up wait is 256 ticks of 128 clocks from release, whatever the divider holds.
		wres();
		chk("reset_wait", 32'(n > 24700 && n < 24800), 32'h1);
		chk("reset_vector", 32'(vec), 32'h0);
		$display("reset test done");
		rd(8'h40, d, r);
		chk("rd_unmapped", 32'(r), 32'(pdc_pkg::RESP_SLVERR));
		wr(8'h44, 32'hFF, r);
		chk("wr_unmapped", 32'(r), 32'(pdc_pkg::RESP_SLVERR));
		do_stop();
		chk("unarmed_osc", 32'(osc_en), 32'h1);
		rchk("unarmed_state", pdc_pkg::OFF_STATUS, 32'h0);
		$display("bus and unarmed test done");
		wr(pdc_pkg::OFF_PDATA, 32'hA5, r);
		wr(pdc_pkg::OFF_PDIR, 32'h0F, r);
		wr(pdc_pkg::OFF_CTRL, 32'h5A, r);
		want_iflag <= 1'b1;
		do_stop();
		chk("clocks", 32'({osc_en, sys_clk_en, periph_clk_en}), 32'h0);
		chk("sio_clk", 32'(sio_clk_en), 32'h0);
		chk("held_pc", 32'(held_pc), 32'(stop_next_pc));
		chk("port_out", 32'(port_out), 32'hA5);
		chk("port_oe_b", 32'(port_oe_b), 32'hF0);
		rchk("stop_state", pdc_pkg::OFF_STATUS, 32'h1);
		want_irq <= 1'b1;
		pulse(4);
		repeat (10) @(posedge ref_clk);
		chk("no_wake", 32'(osc_en), 32'h0);
		want_irq <= 1'b0;
		pulse(0);
		wres();
		chk("stab_len", 32'(n >= 4064 && n <= 4128), 32'h1);
		chk("vector", 32'(vec), 32'h1);
		chk("pend_ext", 32'(wake_pending), 32'h01);
		rchk("ctrl_clr", pdc_pkg::OFF_CTRL, 32'h0);
		rchk("pdata_kept", pdc_pkg::OFF_PDATA, 32'hA5);
		wr(pdc_pkg::OFF_PEND, 32'h1F, r);
		$display("stop by external interrupt done");
		want_iflag <= 1'b0;
		sio_ext_clk_sel <= 1'b1;
		for (int k = 1; k < 5; k++) begin
			rd(pdc_pkg::OFF_EVCNT, e, r);
			wr(pdc_pkg::OFF_CTRL, 32'h5A, r);
			do_stop();
			chk("stopped", 32'(osc_en), 32'h0);
			chk("sio_ext_clk", 32'(sio_clk_en), 32'h1);
			pulse(k);
			wres();
			chk("vector_off", 32'(vec), 32'h0);
			chk("pend_bit", 32'(wake_pending[k]), 32'h1);
			rd(pdc_pkg::OFF_EVCNT, d, r);
			chk("evcnt", 32'(d[7:0]), 32'(e[7:0] + ((k == 1) ? 8'h01 : 8'h00)));
			wr(pdc_pkg::OFF_PEND, 32'h1F, r);
			rchk("pend_clr", pdc_pkg::OFF_PEND, 32'h0);
		end
		$display("stop wake source test done");
		want_iflag <= 1'b1;
		wr(pdc_pkg::OFF_CTRL, 32'h0F, r);
		rchk("sleep_state", pdc_pkg::OFF_STATUS, 32'h2);
		chk("sleep_clk", 32'({osc_en, periph_clk_en, cpu_run}), 32'h6);
		want_irq <= 1'b1;
		wres();
		want_irq <= 1'b0;
		chk("sleep_wake", 32'(n < 5000), 32'h1);
		chk("sleep_vec", 32'(vec), 32'h1);
		$display("sleep test done");
		wr(pdc_pkg::OFF_CTRL, 32'h5A, r);
		do_stop();
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk("reset_osc", 32'(osc_en), 32'h1);
		rchk("rst_ctrl", pdc_pkg::OFF_CTRL, 32'h0);
		rchk("rst_div", pdc_pkg::OFF_DIV, 32'(pdc_pkg::DIV_RST));
		rchk("rst_pdata", pdc_pkg::OFF_PDATA, 32'h0);
		rchk("rst_state", pdc_pkg::OFF_STATUS, 32'h3);
		$display("reset in stop test done");
		close_out();
	end
endmodule // stop_mode_power_down_control_tb
